// ---- pkg/arf_pkg.sv ----
/*
  Shared constants, types and helpers for the conversion-result formatting
  block: register offsets, field positions, reset values, trigger codes,
  acquisition timing and the justification formatter.
  Assumes a 40 MHz APB clock and a 10-bit converter result.
*/
package arf_pkg;

  // Register byte offsets on APB
  localparam logic [11:0] ARF_OFS_CTRL = 12'h000;
  localparam logic [11:0] ARF_OFS_RES_HI = 12'h004;
  localparam logic [11:0] ARF_OFS_RES_LO = 12'h008;
  localparam logic [11:0] ARF_OFS_FLAGS = 12'h00C;
  localparam logic [11:0] ARF_OFS_STATUS = 12'h010;

  // Control register fields
  localparam int ARF_CTRL_EN_BIT = 0;
  localparam int ARF_CTRL_GO_BIT = 1;
  localparam int ARF_CTRL_CHAN_LSB = 2;
  localparam int ARF_CTRL_JUST_BIT = 7;
  localparam int ARF_CTRL_TRIG_LSB = 8;
  localparam int ARF_CHAN_W = 5;
  localparam int ARF_TRIG_W = 3;

  // Status register fields
  localparam int ARF_STAT_BUSY_BIT = 0;
  localparam int ARF_STAT_ACQ_BIT = 1;

  // Values after reset
  localparam logic [ARF_CHAN_W-1:0] ARF_CHAN_RESET = 5'h00;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_RESET = 3'h0;
  localparam logic [2:0] ARF_FLAGS_RESET = 3'h0;

  // Auto-conversion trigger source codes
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_NONE = 3'h0;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_TMR0 = 3'h3;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_TMR1 = 3'h4;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_TMR2 = 3'h5;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_CMP1 = 3'h6;
  localparam logic [ARF_TRIG_W-1:0] ARF_TRIG_CMP2 = 3'h7;

  // Acquisition time before a conversion, least time rounds up
  localparam int ARF_CLK_PERIOD_NS = 25;
  localparam int ARF_ACQ_TIME_NS = 8100;
  localparam int ARF_ACQ_CYCLES = (ARF_ACQ_TIME_NS + ARF_CLK_PERIOD_NS - 1) / ARF_CLK_PERIOD_NS;
  localparam int ARF_ACQ_W = 10;
  localparam logic [ARF_ACQ_W-1:0] ARF_ACQ_LOAD = ARF_ACQ_W'(ARF_ACQ_CYCLES);

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} arf_state_e;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } arf_result_s;

  // Place a 10-bit result into the two 8-bit result registers
  function automatic arf_result_s arf_format(input logic right_just, input logic [9:0] res);
    arf_result_s r;
    if (right_just)
    begin
      r.hi = {6'h00, res[9:8]};
      r.lo = res[7:0];
    end
    else
    begin
      r.hi = res[9:2];
      r.lo = {res[1:0], 6'h00};
    end
    return r;
  endfunction

endpackage

// ---- verilog/arf_result_store.sv ----
/*
  Storage for the two result registers. Holds no reset on purpose so that
  the contents survive any reset after power-up and start unknown.
  Assumes writes come from the same pclk domain; a hardware update wins
  over a software write in the same cycle.
*/
`timescale 1ns/10ps
module arf_result_store
  import arf_pkg::*;
(
  input wire logic pclk,
  input wire logic hw_we,
  input wire arf_result_s hw_data,
  input wire logic sw_we_hi,
  input wire logic sw_we_lo,
  input wire logic [7:0] sw_data,
  output arf_result_s store_q
);

  // No reset term: value is unknown at power-up and kept across resets
  always_ff @(posedge pclk)
  begin
    if (hw_we)
    begin
      store_q <= hw_data;
    end
    else
    begin
      if (sw_we_hi)
      begin
        store_q.hi <= sw_data;
      end
      if (sw_we_lo)
      begin
        store_q.lo <= sw_data;
      end
    end
  end

endmodule

// ---- verilog/arf_top.sv ----
/*
  Conversion control and result formatting: APB register file, start and
  acquisition sequencing toward the converter, trigger edge detection with
  timer flags, and justified result capture.
  Assumes converter handshake and trigger inputs are pclk-domain logic.
*/
`timescale 1ns/10ps
// Contract
// - Left justified, result bits 9..2 fill the upper result register.
// - Left justified, result bits 1..0 go to bits 7..6 of the lower register.
// - Right justified, result bits 9..8 go to bits 1..0 of the upper register.
// - Right justified, result bits 7..0 fill the lower result register.
// - Result registers are read/write, unknown at power-up, kept over other resets.
// - The hold capacitor is not discharged when a conversion ends.
// - A timer trigger source firing sets its own flag regardless of conversion.
module arf_top
  import arf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] trig_src,
  input wire logic conv_done,
  input wire logic [9:0] conversion_result,
  output logic conv_start,
  output logic sample_switch,
  output logic [ARF_CHAN_W-1:0] chan_select,
  output logic [2:0] timer_flags
);

  logic en_q;
  logic result_justify_select_q;
  logic [ARF_CHAN_W-1:0] chan_q;
  logic [ARF_TRIG_W-1:0] trig_sel_q;
  logic [2:0] flags_q;
  logic [4:0] trig_prev_q;
  logic [ARF_ACQ_W-1:0] acq_cnt_q;
  arf_state_e state_q;
  logic [31:0] prdata_q;
  arf_result_s store_q;
  arf_result_s fmt;
  logic wr_acc;
  logic rd_setup;
  logic sel_ctrl;
  logic sel_hi;
  logic sel_lo;
  logic sel_flags;
  logic sel_stat;
  logic mapped;
  logic [4:0] trig_rise;
  logic trig_fire;
  logic go_req;
  logic start_req;
  logic conv_accept;
  logic acq_reload;
  logic [31:0] rd_mux;

  // Assertion timing: pclk, silent while in reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Decode once, shared by write and read paths
  assign sel_ctrl = (paddr == ARF_OFS_CTRL);
  assign sel_hi = (paddr == ARF_OFS_RES_HI);
  assign sel_lo = (paddr == ARF_OFS_RES_LO);
  assign sel_flags = (paddr == ARF_OFS_FLAGS);
  assign sel_stat = (paddr == ARF_OFS_STATUS);
  assign mapped = sel_ctrl | sel_hi | sel_lo | sel_flags | sel_stat;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  // Edge detect on trigger sources, all rising-edge sensitive
  assign trig_rise = trig_src & ~trig_prev_q;

  always_comb
  begin
    unique case (trig_sel_q)
      ARF_TRIG_TMR0: trig_fire = trig_rise[0];
      ARF_TRIG_TMR1: trig_fire = trig_rise[1];
      ARF_TRIG_TMR2: trig_fire = trig_rise[2];
      ARF_TRIG_CMP1: trig_fire = trig_rise[3];
      ARF_TRIG_CMP2: trig_fire = trig_rise[4];
      default: trig_fire = 1'b0;
    endcase
  end

  // Start from software go bit or selected trigger
  assign go_req = wr_acc & sel_ctrl & pstrb[0] & pwdata[ARF_CTRL_GO_BIT];
  assign start_req = en_q & (go_req | trig_fire);
  assign conv_accept = (state_q == ST_CONV) & conv_done;
  assign fmt = arf_format(result_justify_select_q, conversion_result);
  assign acq_reload = (wr_acc & sel_ctrl & pstrb[0]
                       & (pwdata[ARF_CTRL_CHAN_LSB +: ARF_CHAN_W] != chan_q)) | conv_accept;

  // Converter-side outputs
  assign conv_start = (state_q == ST_ACQ) & (acq_cnt_q == '0);
  assign sample_switch = en_q & (state_q != ST_CONV);
  assign chan_select = chan_q;
  assign timer_flags = flags_q;

  // Trigger history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_prev_q <= 5'h00;
    end
    else
    begin
      trig_prev_q <= trig_src;
    end
  end

  // Control register; byte lanes honoured
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      result_justify_select_q <= 1'b0;
      chan_q <= ARF_CHAN_RESET;
      trig_sel_q <= ARF_TRIG_RESET;
    end
    else if (wr_acc & sel_ctrl)
    begin
      if (pstrb[0])
      begin
        en_q <= pwdata[ARF_CTRL_EN_BIT];
        chan_q <= pwdata[ARF_CTRL_CHAN_LSB +: ARF_CHAN_W];
        result_justify_select_q <= pwdata[ARF_CTRL_JUST_BIT];
      end
      if (pstrb[1])
      begin
        trig_sel_q <= pwdata[ARF_CTRL_TRIG_LSB +: ARF_TRIG_W];
      end
    end
  end

  // Timer flags: set wins over write-one-to-clear so no event is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= ARF_FLAGS_RESET;
    end
    else
    begin
      flags_q <= (flags_q & ~((wr_acc & sel_flags & pstrb[0]) ? pwdata[2:0] : 3'h0))
                 | trig_rise[2:0];
    end
  end

  // Settling counter restarts on channel change and after each conversion,
  // because the hold capacitor must track the new input before sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acq_cnt_q <= ARF_ACQ_LOAD;
    end
    else if (acq_reload)
    begin
      acq_cnt_q <= ARF_ACQ_LOAD;
    end
    else if (sample_switch && acq_cnt_q != '0)
    begin
      acq_cnt_q <= acq_cnt_q - ARF_ACQ_W'(1);
    end
  end

  // Sequencer; disabling aborts a pending or running conversion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
    end
    else if (!en_q)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_req)
          begin
            state_q <= ST_ACQ;
          end
        end
        ST_ACQ:
        begin
          if (conv_start)
          begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          // Return to tracking with no discharge step
          if (conv_done)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Result registers live in the store; hardware capture of both at once
  arf_result_store u_store (
    .pclk(pclk),
    .hw_we(conv_accept),
    .hw_data(fmt),
    .sw_we_hi(wr_acc & sel_hi & pstrb[0]),
    .sw_we_lo(wr_acc & sel_lo & pstrb[0]),
    .sw_data(pwdata[7:0]),
    .store_q(store_q)
  );

  // Read mux; reserved bits read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
    begin
      rd_mux[ARF_CTRL_EN_BIT] = en_q;
      rd_mux[ARF_CTRL_GO_BIT] = (state_q != ST_IDLE);
      rd_mux[ARF_CTRL_CHAN_LSB +: ARF_CHAN_W] = chan_q;
      rd_mux[ARF_CTRL_JUST_BIT] = result_justify_select_q;
      rd_mux[ARF_CTRL_TRIG_LSB +: ARF_TRIG_W] = trig_sel_q;
    end
    if (sel_hi)
    begin
      rd_mux[7:0] = store_q.hi;
    end
    if (sel_lo)
    begin
      rd_mux[7:0] = store_q.lo;
    end
    if (sel_flags)
    begin
      rd_mux[2:0] = flags_q;
    end
    if (sel_stat)
    begin
      rd_mux[ARF_STAT_BUSY_BIT] = (state_q != ST_IDLE);
      rd_mux[ARF_STAT_ACQ_BIT] = (acq_cnt_q != '0);
    end
  end

  // Read data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata_q <= rd_mux;
    end
  end

  sequence s_conv_left;
    conv_accept && !result_justify_select_q;
  endsequence

  sequence s_conv_right;
    conv_accept && result_justify_select_q;
  endsequence

  a_left_upper_bits: assert property (
    s_conv_left |=> store_q.hi == $past(conversion_result[9:2]))
    else $error("upper register wrong in left mode");

  a_left_lower_bits: assert property (
    s_conv_left |=> store_q.lo[7:6] == $past(conversion_result[1:0]))
    else $error("lower register top bits wrong in left mode");

  a_right_upper_bits: assert property (
    s_conv_right |=> store_q.hi[1:0] == $past(conversion_result[9:8]))
    else $error("upper register low bits wrong in right mode");

  a_right_lower_bits: assert property (
    s_conv_right |=> store_q.lo == $past(conversion_result[7:0]))
    else $error("lower register wrong in right mode");

  a_result_sw_write: assert property (
    (wr_acc && sel_lo && pstrb[0] && !conv_accept) ##1 !conv_accept [*2]
    |-> store_q.lo == $past(pwdata[7:0], 2))
    else $error("software write to lower result not kept");

  a_acq_before_start: assert property (
    acq_reload ##1 (state_q == ST_ACQ) |-> !conv_start [*8])
    else $error("conversion started without acquisition");

  a_hold_reconnect: assert property (
    conv_accept && en_q && !(wr_acc && sel_ctrl) |=> sample_switch && state_q == ST_IDLE)
    else $error("sampling not resumed after conversion");

  a_timer_flag_set: assert property (
    trig_rise[0] |=> flags_q[0] ##1 (flags_q[0] || ($past(wr_acc) && $past(sel_flags))))
    else $error("timer flag not set on trigger");

  a_both_same_cycle: assert property (
    conv_accept |=> store_q == arf_format($past(result_justify_select_q),
                                          $past(conversion_result)))
    else $error("result registers not updated together");

endmodule

// ---- verif/arf_top_bench.sv ----
/*
  Self-checking bench for arf_top: APB read and write tasks, converter
  handshake and trigger stimulus, with expected values built here.
  Assumes a zero-wait APB slave and a 40 MHz pclk; no partner model.
*/
`timescale 1ns/10ps
module arf_top_bench;
  import arf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [4:0] trig_src = 5'h00;
  logic conv_done = 1'b0;
  logic [9:0] conversion_result = 10'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_start;
  logic sample_switch;
  logic [ARF_CHAN_W-1:0] chan_select;
  logic [2:0] timer_flags;
  logic [31:0] rd;
  logic err;
  logic [9:0] res;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int last_end = 0;
  int acq = 0;
  localparam logic [31:0] EN = 32'h1 << ARF_CTRL_EN_BIT;
  localparam logic [31:0] GO = 32'h1 << ARF_CTRL_GO_BIT;
  localparam logic [31:0] JR = 32'h1 << ARF_CTRL_JUST_BIT;

  arf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_src(trig_src), .conv_done(conv_done),
    .conversion_result(conversion_result), .conv_start(conv_start),
    .sample_switch(sample_switch), .chan_select(chan_select), .timer_flags(timer_flags));

  // Free-running pclk, 25 ns period
  always #12.5 pclk = ~pclk;

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; idle cycle after it so strobes never change twice per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the hang guard ends a wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // Expected layout worked out from the justification choice
  task automatic chk_res(input logic j, input logic [9:0] r);
    rd_chk(ARF_OFS_RES_HI, j ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
    rd_chk(ARF_OFS_RES_LO, j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00});
  endtask

  // Wait for start, answer with a result one cycle into the conversion
  task automatic convert(input logic [9:0] r);
    do
    begin
      @(negedge pclk);
    end
    while (conv_start !== 1'b1);
    acq = cycles - last_end;
    @(posedge pclk);
    @(negedge pclk);
    check(sample_switch, 32'h0);
    @(posedge pclk);
    conv_done <= 1'b1;
    conversion_result <= r;
    @(posedge pclk);
    conv_done <= 1'b0;
    conversion_result <= ~r; // Released bus no longer shows the result
    last_end = cycles;
    @(negedge pclk);
    check(sample_switch, 32'h1);
    @(posedge pclk);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ARF_OFS_CTRL, 32'h0);
    rd_chk(ARF_OFS_FLAGS, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    end_test("reset and unmapped");
    apb(1'b1, ARF_OFS_RES_HI, 32'h000000A5);
    apb(1'b1, ARF_OFS_RES_LO, 32'h0000005A);
    rd_chk(ARF_OFS_RES_HI, 32'h000000A5);
    rd_chk(ARF_OFS_RES_LO, 32'h0000005A);
    end_test("result access");
    // Enable first: a go bit is only taken once enabled
    apb(1'b1, ARF_OFS_CTRL, EN);
    apb(1'b1, ARF_OFS_CTRL, EN | GO);
    convert(10'h2D7);
    chk_res(1'b0, 10'h2D7);
    apb(1'b1, ARF_OFS_CTRL, EN | GO | JR);
    convert(10'h16B);
    check(32'(acq >= ARF_ACQ_CYCLES - 3 && acq <= ARF_ACQ_CYCLES + 3), 32'h1);
    chk_res(1'b1, 10'h16B);
    // Channel change with go: settling restarts from the change
    apb(1'b1, ARF_OFS_CTRL, EN | GO | (32'h5 << ARF_CTRL_CHAN_LSB));
    last_end = cycles;
    check(chan_select, 32'h5);
    convert(10'h0C3);
    check(32'(acq >= ARF_ACQ_CYCLES - 3 && acq <= ARF_ACQ_CYCLES + 3), 32'h1);
    chk_res(1'b0, 10'h0C3);
    end_test("go conversions");
    // Every trigger code, alternating justification; timer codes also flag
    for (int k = 3; k < 8; k++)
    begin
      res = 10'h3FF - 10'(k * 93);
      apb(1'b1, ARF_OFS_CTRL,
          EN | (32'(k) << ARF_CTRL_TRIG_LSB) | (32'(k & 1) << ARF_CTRL_JUST_BIT));
      trig_src <= 5'h01 << (k - 3);
      convert(res);
      chk_res(k[0], res);
      if (k < 6)
        check(timer_flags[k - 3], 32'h1);
    end
    rd_chk(ARF_OFS_FLAGS, 32'h7);
    apb(1'b1, ARF_OFS_FLAGS, 32'h7);
    rd_chk(ARF_OFS_FLAGS, 32'h0);
    end_test("triggers");
    // Warm reset keeps the last result
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_res(1'b1, res);
    end_test("reset retention");
    finish_test();
  end
endmodule
